// file: dv/hpp_board_model.sv
`timescale 1ns/1ns
`default_nettype none
// Board around the hub: power switches, the serial memory and the strap resistors.
module hpp_board_model (
  input wire logic ganged,
  input wire logic gang_strap,
  input wire logic mem_mode,
  input wire logic [3:0] fault,
  input wire logic dut_oe,
  input wire logic dut_out,
  input wire logic mem_drive,
  input wire logic mem_level,
  output logic [3:0] overcurrent_n,
  output logic pin_level
);
  // A switch pulls its flag low on a fault; ganged boards share one flag net.
  always_comb begin
    overcurrent_n = ganged ? {4{~|fault}} : ~fault;
  end

  // The shared pin follows its driver; undriven it rests on the pull-down or the strap.
  always_comb begin
    if (dut_oe) begin
      pin_level = dut_out;
    end else if (mem_mode && mem_drive) begin
      pin_level = mem_level;
    end else begin
      pin_level = mem_mode ? 1'h0 : gang_strap;
    end
  end
endmodule // hpp_board_model
`default_nettype wire

// file: dv/tb_hpp_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_hpp_top;
  import hpp_pkg::*;
  // One expected result: the output group it concerns and its value.
  typedef struct {
    int kind;
    logic [5:0] value;
  } hpp_note_t;
  logic clk, rst_n, pwr, mem, sel, gang, gwire, mclk, mdrv, mout, susp, edrv, elvl;
  logic pin, pout, poe, sclk, sclk_oe, mdin, sus, bus_p, gmode, defid, fast, pll, ready;
  logic [NUM_PORTS-1:0] fault, req, oc_n, en_n, oc;
  logic [31:0] r;
  int num_errors, compares;
  hpp_note_t notes[$];
  event note_ready;
  string names[5] = '{"power_enable_n", "overcurrent", "config", "memory_pins", "suspend"};

  hpp_top DUT (.CLK(clk), .RST_N(rst_n), .POWER_SOURCE_STRAP(pwr), .EXT_MEMORY_ENABLE(mem),
    .CLOCK_SOURCE_SELECT(sel), .PORT_OVERCURRENT_N(oc_n), .PORT_POWER_REQ(req),
    .SUSPEND_REQ(susp), .MEM_CLOCK_REQ(mclk), .MEM_DATA_DRIVE(mdrv), .MEM_DATA_OUT(mout),
    .DATA_OR_GANG_IN(pin), .DATA_OR_GANG_OUT(pout), .DATA_OR_GANG_OE(poe),
    .SERIAL_MEMORY_CLOCK(sclk), .SERIAL_MEMORY_CLOCK_OE(sclk_oe), .MEM_DATA_IN(mdin),
    .PORT_POWER_ENABLE_N(en_n), .PORT_OVERCURRENT(oc), .SUSPEND_STATUS(sus),
    .BUS_POWERED(bus_p), .GANGED_MODE(gmode), .DEFAULT_IDENTITY(defid),
    .FAST_CLOCK_SELECT(fast), .PLL_ENABLE(pll), .CONFIG_READY(ready));

  hpp_board_model board (.ganged(gwire), .gang_strap(gang), .mem_mode(~mem), .fault(fault),
    .dut_oe(poe), .dut_out(pout), .mem_drive(edrv), .mem_level(elvl),
    .overcurrent_n(oc_n), .pin_level(pin));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Gathers one output group as a vector for comparison.
  function automatic logic [5:0] observe(input int kind);
    case (kind)
      0: return {2'h0, en_n};
      1: return {2'h0, oc};
      2: return {bus_p, gmode, defid, fast, pll, ready};
      3: return {1'h0, sclk, sclk_oe, pout, poe, mdin};
      default: return {5'h0, sus};
    endcase
  endfunction

  // Compares one bit vector and counts the outcome.
  task automatic compare_bits(input string name, input logic [5:0] exp, input logic [5:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Takes the oldest notes off the queue as soon as their results are due.
  always @(note_ready) begin
    while (notes.size() > 0) begin
      compare_bits(names[notes[0].kind], notes[0].value, observe(notes[0].kind));
      void'(notes.pop_front());
    end
  end

  // Records an expected result that is settled now.
  task automatic note(input int kind, input logic [5:0] value);
    notes.push_back('{kind, value});
    -> note_ready;
  endtask

  // Lets edges pass, then waits until the outputs have settled.
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Resets with new straps, checks reset values and the captured configuration.
  task automatic restart(input logic p, input logic m, input logic s, input logic g);
    @(negedge clk);
    rst_n = 1'h0;
    pwr = p;
    mem = m;
    sel = s;
    gang = g;
    gwire = m & g;
    cycles(6);
    note(0, 6'h0f);
    note(2, 6'h0a);
    note(3, 6'h00);
    @(negedge clk);
    rst_n = 1'h1;
    cycles(10);
    note(2, {p, m & g, m, s, ~s, 1'h1});
  endtask

  // Applies power requests and the suspend state for one edge.
  task automatic step(input logic [3:0] q, input logic s);
    @(negedge clk);
    req = q;
    susp = s;
    cycles(1);
  endtask

  // Holds a fault pattern at the switches for a number of cycles.
  task automatic hit(input logic [3:0] f, input int len);
    @(negedge clk);
    fault = f;
    cycles(len);
  endtask

  // Sets the core's serial memory requests and the memory's own drive.
  task automatic memreq(input logic c, input logic d, input logic o, input logic e, input int n);
    @(negedge clk);
    mclk = c;
    mdrv = d;
    mout = o;
    edrv = e;
    elvl = 1'h1;
    cycles(n);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  // Main sequence: per-port, ganged and serial memory configurations.
  initial begin
    {rst_n, pwr, mem, sel, gang, gwire, mclk, mdrv, mout, susp, edrv, elvl} = 12'h0;
    fault = 4'h0;
    req = 4'h0;
    void'($urandom(32'h4eaa));
    restart(1'h1, 1'h1, 1'h0, 1'h0);
    for (int i = 0; i < 8; i++) begin
      r = $urandom();
      step(r[3:0], r[4]);
      note(0, {2'h0, ~r[3:0]});
      note(4, {5'h0, r[4]});
    end
    step(4'hf, 1'h0);
    hit(4'h4, 20);
    hit(4'h0, 60);
    note(1, 6'h00);
    note(0, 6'h00);
    // Faults on ports 0 and 2 leave ports 1 and 3 powered.
    hit(4'h5, 60);
    note(1, 6'h05);
    note(0, 6'h05);
    hit(4'h0, 60);
    note(0, 6'h00);
    @(negedge clk);
    pwr = 1'h0;
    cycles(10);
    note(2, 6'h2b);
    pwr = 1'h1;
    $display("test per_port done");
    restart(1'h0, 1'h1, 1'h1, 1'h1);
    step(4'h2, 1'h0);
    note(0, 6'h00);
    hit(4'h2, 60);
    note(1, 6'h0f);
    note(0, 6'h0f);
    hit(4'h0, 60);
    note(0, 6'h00);
    memreq(1'h1, 1'h1, 1'h1, 1'h0, 1);
    note(3, 6'h00);
    $display("test ganged done");
    restart(1'h1, 1'h0, 1'h0, 1'h1);
    memreq(1'h1, 1'h1, 1'h1, 1'h0, 1);
    // The hub reads back the level that it drives on the shared pin.
    note(3, 6'h1f);
    memreq(1'h1, 1'h0, 1'h0, 1'h1, 6);
    note(3, 6'h19);
    memreq(1'h1, 1'h0, 1'h0, 1'h0, 6);
    note(3, 6'h18);
    $display("test memory done");
    // Let the checker take the last note before the verdict.
    @(negedge clk);
    complete_run();
  end
endmodule // tb_hpp_top
`default_nettype wire

// file: verilog/hpp_glitch_filter.sv
`timescale 1ns/1ns
`default_nettype none
module hpp_glitch_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  import hpp_pkg::*;

  // Three-stage synchroniser for the asynchronous pin.
  logic s1;
  logic s2;
  logic s3;
  // Cycles for which the new level has been seen steadily.
  logic [OC_CNT_W-1:0] cnt;

  // Synchroniser chain; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= OC_IDLE_N;
      s2 <= OC_IDLE_N;
      s3 <= OC_IDLE_N;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A new level is taken only after it stands for the whole filter length.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      dout <= OC_IDLE_N;
    end else if (s2 != s3 || s3 == dout) begin
      // Disagreement or no change restarts the window.
      cnt <= '0; // [RL11]
    end else if (cnt == OC_CNT_W'(OC_FILTER_CYCLES - 1)) begin
      // The level survived the window, so it is real.
      dout <= s3; // [RL11]
      cnt <= '0;
    end else begin
      cnt <= cnt + OC_CNT_W'(1);
    end
  end

  // The output moves only after a full steady window.
  property p_filter_window;
    @(posedge clk) disable iff (!rst_n)
      $changed(dout) |-> ($past(cnt) == OC_CNT_W'(OC_FILTER_CYCLES - 1)) && ($past(s3) == dout);
  endproperty
  a_filter_window: assert property (p_filter_window) // [RL11]
    else $error("Filtered overcurrent changed without a full steady window.");

endmodule // hpp_glitch_filter
`default_nettype wire

// file: verilog/hpp_pkg.sv
// Function
// (RL1) High power strap means bus-powered ports.
// (RL2) Board holds power strap fixed after reset.
// (RL3) Memory enable high keeps memory pins idle.
// (RL4) Memory enable low drives three-state memory clock.
// (RL5) Memory data pin bidirectional, released when idle.
// (RL6) Memory disabled: shared pin is gang strap.
// (RL7) Board holds gang strap level constant.
// (RL8) Per-port mode: each overcurrent owns one port.
// (RL9) Ganged mode: any overcurrent input counts.
// (RL10) Board ties overcurrent inputs together when ganged.
// (RL11) Overcurrent inputs are noise filtered.
// (RL12) Power enables are active-low push-pull outputs.
// (RL13) Reset initialises all logic.
// (RL14) Board asserts reset at power-up, 100us-1ms.
// (RL15) Clock runs during last 60us of reset.
// (RL16) Suspend status high in suspend, else low.
// (RL17) Clock select low crystal, high direct clock.
// (RL18) Board supplies oscillator or grounds fast input.
// (RL19) Crystal mode uses internal PLL clocks.
// (RL20) One upstream, four downstream ports.
// (RL21) Ganged switches together; per-port acts separately.
// (RL22) Memory disabled reports default product identity.
// (RL23) Straps captured at reset release, then held.
// (RL24) Per-port overcurrent turns off only that port.
package hpp_pkg;

  // Number of downstream ports served by the hub.
  localparam int NUM_PORTS = 4;

  // Clock period of the control logic in nanoseconds.
  localparam int CLK_PERIOD_NS = 20;

  // Shortest overcurrent level that is believed, in nanoseconds.
  localparam int OC_FILTER_NS = 1000;

  // Filter length in cycles, rounded up to whole cycles.
  localparam int OC_FILTER_CYCLES = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the filter counter.
  localparam int OC_CNT_W = 6;

  // Cycles waited after reset release before the straps are captured.
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

  // Bit positions inside the synchronised strap vector.
  localparam int STRAP_POWER = 0;
  localparam int STRAP_EXT_MEMORY_ENABLE = 1;
  localparam int STRAP_CLKSEL = 2;
  localparam int STRAP_GANG = 3;

  // Reset value of the active-low power enables: all ports off.
  localparam logic [3:0] POWER_OFF_N = 4'hf;

  // Reset value of the active-low overcurrent sense: no fault.
  localparam logic OC_IDLE_N = 1'h1;

  // Control sequence after reset.
  typedef enum logic [0:0] {
    ST_SETTLE,
    ST_RUN
  } hpp_state_t;

endpackage

// file: verilog/hpp_top.sv
`timescale 1ns/1ns
`default_nettype none
module hpp_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic POWER_SOURCE_STRAP,
  input wire logic EXT_MEMORY_ENABLE,
  input wire logic CLOCK_SOURCE_SELECT,
  input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_OVERCURRENT_N,
  input wire logic [hpp_pkg::NUM_PORTS-1:0] PORT_POWER_REQ,
  input wire logic SUSPEND_REQ,
  input wire logic MEM_CLOCK_REQ,
  input wire logic MEM_DATA_DRIVE,
  input wire logic MEM_DATA_OUT,
  input wire logic DATA_OR_GANG_IN,
  output logic DATA_OR_GANG_OUT,
  output logic DATA_OR_GANG_OE,
  output logic SERIAL_MEMORY_CLOCK,
  output logic SERIAL_MEMORY_CLOCK_OE,
  output logic MEM_DATA_IN,
  output logic [hpp_pkg::NUM_PORTS-1:0] PORT_POWER_ENABLE_N,
  output logic [hpp_pkg::NUM_PORTS-1:0] PORT_OVERCURRENT,
  output logic SUSPEND_STATUS,
  output logic BUS_POWERED,
  output logic GANGED_MODE,
  output logic DEFAULT_IDENTITY,
  output logic FAST_CLOCK_SELECT,
  output logic PLL_ENABLE,
  output logic CONFIG_READY
);
  import hpp_pkg::*;

  // Synchronised strap pins, three stages each.
  logic [3:0] strap_s1;
  logic [3:0] strap_s2;
  logic [3:0] strap_s3;
  // Synchronised memory data input, three stages.
  logic [2:0] mdat_sync;
  // Straps held from capture until the next reset.
  logic cap_power;
  logic cap_ext_memory_enable;
  logic cap_clksel;
  logic cap_gang;
  // Sequencer state and settle counter.
  hpp_state_t state;
  hpp_state_t next_state;
  logic [2:0] settle_cnt;
  // Filtered active-low overcurrent per port.
  logic [NUM_PORTS-1:0] oc_filt_n;
  // Overcurrent seen by each port after mode selection.
  logic [NUM_PORTS-1:0] oc_eff;
  // Power request after mode selection and overcurrent shut-off.
  logic [NUM_PORTS-1:0] next_power_on;

  // Apply the ganged or per-port view to a per-port vector.
  function automatic logic [NUM_PORTS-1:0] gang_view(input logic gang,
                                                     input logic [NUM_PORTS-1:0] v);
    gang_view = gang ? {NUM_PORTS{|v}} : v;
  endfunction

  // Strap synchronisers; the first stage feeds only the second.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
      strap_s3 <= 4'h0;
    end else begin
      strap_s1 <= {DATA_OR_GANG_IN, CLOCK_SOURCE_SELECT, EXT_MEMORY_ENABLE, POWER_SOURCE_STRAP};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
    end
  end

  // Memory data synchroniser; the settled level is the returned data.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mdat_sync <= 3'h0;
    end else begin
      mdat_sync <= {mdat_sync[1:0], DATA_OR_GANG_IN};
    end
  end

  // Returned memory data changes once stages two and three agree.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MEM_DATA_IN <= 1'h0;
    end else if (!cap_ext_memory_enable && mdat_sync[1] == mdat_sync[2]) begin
      MEM_DATA_IN <= mdat_sync[2]; // [RL5]
    end
  end

  // Next state: leave settling once the pipeline is full and the straps agree.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_SETTLE: begin
        if (settle_cnt == STRAP_SETTLE_CYCLES && strap_s2 == strap_s3) begin
          next_state = ST_RUN; // [RL23]
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // Sequencer; reset puts all control back to its start state.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_SETTLE; // [RL13]
      settle_cnt <= 3'h0;
    end else begin
      state <= next_state;
      if (settle_cnt != STRAP_SETTLE_CYCLES) begin
        settle_cnt <= settle_cnt + 3'h1;
      end
    end
  end

  // Strap capture at the end of settling; held until the next reset.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_power <= 1'h0;
      cap_ext_memory_enable <= 1'h1;
      cap_clksel <= 1'h0;
      cap_gang <= 1'h0;
    end else if (state == ST_SETTLE && next_state == ST_RUN) begin
      cap_power <= strap_s3[STRAP_POWER]; // [RL23]
      cap_ext_memory_enable <= strap_s3[STRAP_EXT_MEMORY_ENABLE];
      cap_clksel <= strap_s3[STRAP_CLKSEL];
      // The shared pin is a gang strap only with the memory disabled.
      cap_gang <= strap_s3[STRAP_EXT_MEMORY_ENABLE] & strap_s3[STRAP_GANG]; // [RL6]
    end
  end

  // One filter per downstream port.
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    hpp_glitch_filter u_filt (
      .clk(CLK),
      .rst_n(RST_N),
      .din(PORT_OVERCURRENT_N[i]), // [RL11]
      .dout(oc_filt_n[i])
    );
  end

  // Mode selection of overcurrent and power requests.
  always_comb begin
    // Ganged: any input is the shared fault; per-port: each its own.
    oc_eff = gang_view(cap_gang, ~oc_filt_n); // [RL8] [RL9]
    // Ganged ports switch together; a fault turns off only where it applies.
    next_power_on = gang_view(cap_gang, PORT_POWER_REQ) & ~oc_eff; // [RL21] [RL24]
  end

  // Push-pull power enables, off until the straps are known.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PORT_POWER_ENABLE_N <= POWER_OFF_N;
      PORT_OVERCURRENT <= '0;
    end else if (state == ST_RUN) begin
      PORT_POWER_ENABLE_N <= ~next_power_on; // [RL12] [RL20]
      PORT_OVERCURRENT <= oc_eff;
    end else begin
      PORT_POWER_ENABLE_N <= POWER_OFF_N;
      PORT_OVERCURRENT <= '0;
    end
  end

  // Serial memory pins follow the core only while the interface is enabled.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SERIAL_MEMORY_CLOCK <= 1'h0;
      SERIAL_MEMORY_CLOCK_OE <= 1'h0;
      DATA_OR_GANG_OUT <= 1'h0;
      DATA_OR_GANG_OE <= 1'h0;
    end else if (state == ST_RUN && !cap_ext_memory_enable) begin
      SERIAL_MEMORY_CLOCK <= MEM_CLOCK_REQ; // [RL4]
      SERIAL_MEMORY_CLOCK_OE <= 1'h1;
      DATA_OR_GANG_OUT <= MEM_DATA_OUT;
      DATA_OR_GANG_OE <= MEM_DATA_DRIVE; // [RL5]
    end else begin
      SERIAL_MEMORY_CLOCK <= 1'h0; // [RL3]
      SERIAL_MEMORY_CLOCK_OE <= 1'h0;
      DATA_OR_GANG_OUT <= 1'h0;
      DATA_OR_GANG_OE <= 1'h0;
    end
  end

  // Suspend status follows the core's suspend request.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SUSPEND_STATUS <= 1'h0;
    end else begin
      SUSPEND_STATUS <= SUSPEND_REQ; // [RL16]
    end
  end

  // Configuration outputs derived from the captured straps; the ready flag follows the sequencer state.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_POWERED <= 1'h0;
      GANGED_MODE <= 1'h0;
      DEFAULT_IDENTITY <= 1'h1;
      FAST_CLOCK_SELECT <= 1'h0;
      PLL_ENABLE <= 1'h1;
      CONFIG_READY <= 1'h0;
    end else begin
      BUS_POWERED <= cap_power; // [RL1]
      GANGED_MODE <= cap_gang;
      DEFAULT_IDENTITY <= cap_ext_memory_enable; // [RL22]
      FAST_CLOCK_SELECT <= cap_clksel; // [RL17]
      PLL_ENABLE <= ~cap_clksel; // [RL19]
      CONFIG_READY <= (state == ST_RUN);
    end
  end

  // Disabled memory interface leaves both shared pins undriven.
  property p_mem_off;
    @(posedge CLK) disable iff (!RST_N)
      (state == ST_RUN && cap_ext_memory_enable) |=> !SERIAL_MEMORY_CLOCK_OE && !DATA_OR_GANG_OE;
  endproperty
  a_mem_off: assert property (p_mem_off) // [RL3]
    else $error("Memory pins driven while memory interface disabled.");

  // Enabled memory interface drives the clock from the core.
  property p_mem_clock;
    @(posedge CLK) disable iff (!RST_N)
      (state == ST_RUN && !cap_ext_memory_enable) |=>
        SERIAL_MEMORY_CLOCK_OE && (SERIAL_MEMORY_CLOCK == $past(MEM_CLOCK_REQ));
  endproperty
  a_mem_clock: assert property (p_mem_clock) // [RL4]
    else $error("Memory clock not driven from core request.");

  // The data pin is released whenever the core does not drive it.
  property p_data_release;
    @(posedge CLK) disable iff (!RST_N)
      !MEM_DATA_DRIVE |=> !DATA_OR_GANG_OE;
  endproperty
  a_data_release: assert property (p_data_release) // [RL5]
    else $error("Data pin driven without a drive request.");

  // Per-port fault on port 0 removes power from port 0.
  property p_port_fault;
    @(posedge CLK) disable iff (!RST_N)
      (state == ST_RUN && !cap_gang && !oc_filt_n[0]) |=> PORT_POWER_ENABLE_N[0];
  endproperty
  a_port_fault: assert property (p_port_fault) // [RL8]
    else $error("Port stayed powered during its own overcurrent.");

  // Per-port fault on port 0 leaves a healthy, requested port 1 powered.
  property p_port_isolate;
    @(posedge CLK) disable iff (!RST_N)
      (state == ST_RUN && !cap_gang && !oc_filt_n[0] && oc_filt_n[1] && PORT_POWER_REQ[1])
        |=> !PORT_POWER_ENABLE_N[1];
  endproperty
  a_port_isolate: assert property (p_port_isolate) // [RL24]
    else $error("Healthy port lost power on a neighbour fault.");

  // Ganged fault on any input turns all ports off.
  property p_gang_fault;
    @(posedge CLK) disable iff (!RST_N)
      (state == ST_RUN && cap_gang && oc_filt_n != 4'hf) |=> PORT_POWER_ENABLE_N == POWER_OFF_N;
  endproperty
  a_gang_fault: assert property (p_gang_fault) // [RL9]
    else $error("Ganged fault did not turn off all ports.");

  // Ganged enables always move together.
  property p_gang_together;
    @(posedge CLK) disable iff (!RST_N)
      GANGED_MODE |-> (PORT_POWER_ENABLE_N == 4'h0 || PORT_POWER_ENABLE_N == 4'hf);
  endproperty
  a_gang_together: assert property (p_gang_together) // [RL21]
    else $error("Ganged power enables differ.");

  // Suspend status tracks the request with one cycle of delay.
  property p_suspend;
    @(posedge CLK) disable iff (!RST_N)
      ##1 SUSPEND_STATUS == $past(SUSPEND_REQ);
  endproperty
  a_suspend: assert property (p_suspend) // [RL16]
    else $error("Suspend status does not follow suspend request.");

  // Captured straps hold once running.
  property p_strap_hold;
    @(posedge CLK) disable iff (!RST_N)
      (state == ST_RUN) |=> $stable({cap_power, cap_ext_memory_enable, cap_clksel, cap_gang});
  endproperty
  a_strap_hold: assert property (p_strap_hold) // [RL23]
    else $error("Captured strap changed after capture.");

  // Clock source outputs agree with each other and the strap.
  property p_clock_select;
    @(posedge CLK) disable iff (!RST_N)
      (state == ST_RUN) |=> FAST_CLOCK_SELECT == $past(cap_clksel) && PLL_ENABLE == !FAST_CLOCK_SELECT;
  endproperty
  a_clock_select: assert property (p_clock_select) // [RL17]
    else $error("Clock source outputs disagree with strap.");

  // Power source flag follows the captured strap.
  property p_bus_power;
    @(posedge CLK) disable iff (!RST_N)
      (state == ST_RUN) |=> BUS_POWERED == $past(cap_power);
  endproperty
  a_bus_power: assert property (p_bus_power) // [RL1]
    else $error("Bus powered flag disagrees with strap.");

endmodule // hpp_top
`default_nettype wire
